// ---- inc/timer_channel_pkg.sv ----
// Shared constants and types for the timer channel
package timer_channel_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_MATCH_A = 8'h14;
  localparam logic [7:0] OFS_MATCH_B = 8'h18;
  localparam logic [7:0] OFS_PERIOD = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  // Control register command bits
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_DISABLE = 1;
  localparam int CTRL_SWTRIG = 2;
  // Mode register fields (shared positions between the two modes)
  localparam int F_SRC_LO = 0;
  localparam int F_INVERT = 3;
  localparam int F_GATE_LO = 4;
  localparam int F_STOP = 6;
  localparam int F_DISABLE = 7;
  localparam int F_EDGE_LO = 8;
  localparam int F_TRIG_PIN = 10;
  localparam int F_EVT_SRC_LO = 10;
  localparam int F_EVT_RESTART = 12;
  localparam int F_PERIOD_RESTART = 14;
  localparam int F_WAVE = 15;
  localparam int F_LOAD_A_LO = 16;
  localparam int F_LOAD_B_LO = 18;
  localparam int F_MATCH_A_EFF_LO = 16;
  localparam int F_PERIOD_EFF_LO = 18;
  localparam int F_EVT_EFF_LO = 20;
  localparam int F_SW_EFF_LO = 22;
  // Prescaler bit whose level is the divided main clock
  localparam int PRESC_W = 10;
  localparam int DIV2_BIT = 0;
  localparam int DIV8_BIT = 2;
  localparam int DIV32_BIT = 4;
  localparam int DIV128_BIT = 6;
  localparam int DIV1024_BIT = 9;
  // Status bits
  localparam int ST_OVERFLOW = 0;
  localparam int ST_MATCH_A = 2;
  localparam int ST_PERIOD = 4;
  localparam int ST_LOAD_A = 5;
  localparam int ST_LOAD_B = 6;
  localparam int ST_TRIG = 7;
  localparam int ST_CLK_ON = 16;
  localparam int ST_IO_A = 17;
  localparam int ST_IO_B = 18;
  localparam logic [1:0] EFF_NONE = 2'h0;
  localparam logic [1:0] EFF_SET = 2'h1;
  localparam logic [1:0] EFF_CLEAR = 2'h2;
  localparam logic [1:0] EFF_TOGGLE = 2'h3;
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_s;
endpackage

// ---- src/timer_channel_mode_config.sv ----
// One 16-bit timer channel with mode register, capture and waveform logic
//
// How it works
// [RULE1] Source code picks divided main clock or line
// [RULE2] Invert bit selects falling edge counting
// [RULE3] Gate field ANDs clock with external line
// [RULE4] Capture: loading B stops counter clock
// [RULE5] Capture: loading B disables counter clock
// [RULE6] Trigger edge: none, rising, falling, both
// [RULE7] Trigger pin: io B or io A
// [RULE8] Period match restarts counter if enabled
// [RULE9] Mode bit picks capture or waveform
// [RULE10] Edge of io A loads match A
// [RULE11] Edge of io A loads match B
// [RULE12] Waveform: period match stops clock
// [RULE13] Waveform: period match disables clock
// [RULE14] Event edge: none, rising, falling, either
// [RULE15] Event source zero makes io B input
// [RULE16] Event restarts counter when enabled
// [RULE17] Match A sets, clears or toggles io A
// [RULE18] Output priority: software, event, period, match
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module timer_channel_mode_config (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [2:0] ext_clock_line_i,
  input wire logic timer_io_a_i,
  output timer_channel_pkg::pin_drive_s timer_io_a_o,
  input wire logic timer_io_b_i,
  output timer_channel_pkg::pin_drive_s timer_io_b_o
);
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] mode_ff;
  logic [15:0] cnt_ff;
  logic [15:0] match_a_ff;
  logic [15:0] match_b_ff;
  logic [15:0] period_ff;
  logic [7:0] sticky_ff;
  logic [timer_channel_pkg::PRESC_W-1:0] presc_ff;
  logic gated_ff;
  logic io_a_ff;
  logic trig_pin_ff;
  logic evt_ff;
  logic en_ff;
  logic stop_ff;
  logic cnt_chg_ff;
  logic io_a_out_ff;

  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic was);
    edge_hit = (sel[0] & now & ~was) | (sel[1] & ~now & was);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  function automatic logic apply_eff(input logic [1:0] eff, input logic cur);
    case (eff)
      timer_channel_pkg::EFF_SET: apply_eff = 1'b1;
      timer_channel_pkg::EFF_CLEAR: apply_eff = 1'b0;
      timer_channel_pkg::EFF_TOGGLE: apply_eff = ~cur;
      default: apply_eff = cur;
    endcase
  endfunction

  // Mode fields
  logic wave;
  logic [2:0] src_sel;
  logic [1:0] gate_sel;
  logic [1:0] edge_sel;
  logic [1:0] evt_src;
  assign wave = mode_ff[timer_channel_pkg::F_WAVE]; // RULE9
  assign src_sel = mode_ff[timer_channel_pkg::F_SRC_LO +: 3];
  assign gate_sel = mode_ff[timer_channel_pkg::F_GATE_LO +: 2];
  assign edge_sel = mode_ff[timer_channel_pkg::F_EDGE_LO +: 2];
  assign evt_src = mode_ff[timer_channel_pkg::F_EVT_SRC_LO +: 2];

  // Bus decode; a write acts at the ack edge, a status read clears where its data is taken
  logic bus_act;
  logic wr;
  logic rd_status;
  logic sw_trig;
  assign bus_act = cyc_i & stb_i & ack_ff;
  assign wr = bus_act & we_i;
  assign rd_status = cyc_i & stb_i & ~ack_ff & ~we_i & (adr_i == timer_channel_pkg::OFS_STATUS);
  assign sw_trig = wr & (adr_i == timer_channel_pkg::OFS_CTRL) & sel_i[0]
                   & dat_i[timer_channel_pkg::CTRL_SWTRIG];
  assign ack_o = ack_ff;
  assign dat_o = rdata_ff;

  // Count clock: selected level, gated, then edge-detected at main clock
  logic sel_lvl;
  logic gated_lvl;
  logic tick;
  logic running;
  always_comb begin
    case (src_sel) // RULE1
      3'h0: sel_lvl = presc_ff[timer_channel_pkg::DIV2_BIT];
      3'h1: sel_lvl = presc_ff[timer_channel_pkg::DIV8_BIT];
      3'h2: sel_lvl = presc_ff[timer_channel_pkg::DIV32_BIT];
      3'h3: sel_lvl = presc_ff[timer_channel_pkg::DIV128_BIT];
      3'h4: sel_lvl = presc_ff[timer_channel_pkg::DIV1024_BIT];
      3'h5: sel_lvl = ext_clock_line_i[0];
      3'h6: sel_lvl = ext_clock_line_i[1];
      default: sel_lvl = ext_clock_line_i[2];
    endcase
  end
  // RULE3
  assign gated_lvl = (gate_sel == 2'h0) ? sel_lvl : (sel_lvl & ext_clock_line_i[gate_sel - 2'h1]);
  assign tick = mode_ff[timer_channel_pkg::F_INVERT] ? (~gated_lvl & gated_ff) // RULE2
                                                     : (gated_lvl & ~gated_ff);
  assign running = en_ff & ~stop_ff;

  // Capture-side events
  logic trig_lvl;
  logic load_a;
  logic load_b;
  logic ext_trig;
  assign trig_lvl = mode_ff[timer_channel_pkg::F_TRIG_PIN] ? timer_io_a_i : timer_io_b_i; // RULE7
  assign load_a = ~wave & edge_hit(mode_ff[timer_channel_pkg::F_LOAD_A_LO +: 2],
                                   timer_io_a_i, io_a_ff); // RULE10
  assign load_b = ~wave & edge_hit(mode_ff[timer_channel_pkg::F_LOAD_B_LO +: 2],
                                   timer_io_a_i, io_a_ff); // RULE11
  assign ext_trig = ~wave & edge_hit(edge_sel, trig_lvl, trig_pin_ff); // RULE6

  // Waveform-side events, plus the period match eq_c that also fires in capture mode
  logic evt_lvl;
  logic ext_evt;
  logic eq_a;
  logic eq_c;
  assign evt_lvl = (evt_src == 2'h0) ? timer_io_b_i : ext_clock_line_i[evt_src - 2'h1]; // RULE15
  assign ext_evt = wave & edge_hit(edge_sel, evt_lvl, evt_ff); // RULE14
  assign eq_a = wave & cnt_chg_ff & (cnt_ff == match_a_ff);
  assign eq_c = cnt_chg_ff & (cnt_ff == period_ff);

  logic restart;
  logic stop_ev;
  logic dis_ev;
  assign restart = sw_trig | ext_trig
                   | (ext_evt & mode_ff[timer_channel_pkg::F_EVT_RESTART]) // RULE16
                   | (eq_c & mode_ff[timer_channel_pkg::F_PERIOD_RESTART]); // RULE8
  assign stop_ev = (load_b & mode_ff[timer_channel_pkg::F_STOP]) // RULE4
                   | (wave & eq_c & mode_ff[timer_channel_pkg::F_STOP]); // RULE12
  assign dis_ev = (load_b & mode_ff[timer_channel_pkg::F_DISABLE]) // RULE5
                  | (wave & eq_c & mode_ff[timer_channel_pkg::F_DISABLE]); // RULE13

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= cyc_i & stb_i & ~ack_ff;
      rdata_ff <= 32'h0000_0000;
      if (cyc_i & stb_i & ~ack_ff & ~we_i) begin
        case (adr_i)
          timer_channel_pkg::OFS_MODE: rdata_ff <= mode_ff;
          timer_channel_pkg::OFS_COUNT: rdata_ff <= {16'h0000, cnt_ff};
          timer_channel_pkg::OFS_MATCH_A: rdata_ff <= {16'h0000, match_a_ff};
          timer_channel_pkg::OFS_MATCH_B: rdata_ff <= {16'h0000, match_b_ff};
          timer_channel_pkg::OFS_PERIOD: rdata_ff <= {16'h0000, period_ff};
          timer_channel_pkg::OFS_STATUS: begin
            rdata_ff <= {24'h00_0000, sticky_ff};
            rdata_ff[timer_channel_pkg::ST_CLK_ON] <= running;
            rdata_ff[timer_channel_pkg::ST_IO_A] <= timer_io_a_o.out;
            rdata_ff[timer_channel_pkg::ST_IO_B] <= timer_io_b_i;
          end
          default: rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ff <= timer_channel_pkg::MODE_RESET;
      period_ff <= timer_channel_pkg::COUNT_RESET;
    end else if (wr & (adr_i == timer_channel_pkg::OFS_MODE)) begin
      mode_ff <= merge(mode_ff, dat_i, sel_i);
    end else if (wr & (adr_i == timer_channel_pkg::OFS_PERIOD)) begin
      period_ff <= 16'(merge({16'h0000, period_ff}, dat_i, sel_i));
    end
  end

  // Match A and B are captured in capture mode, writable only in waveform mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_a_ff <= timer_channel_pkg::COUNT_RESET;
      match_b_ff <= timer_channel_pkg::COUNT_RESET;
    end else begin
      if (load_a) begin
        match_a_ff <= cnt_ff; // RULE10
      end else if (wave & wr & (adr_i == timer_channel_pkg::OFS_MATCH_A)) begin
        match_a_ff <= 16'(merge({16'h0000, match_a_ff}, dat_i, sel_i));
      end
      if (load_b) begin
        match_b_ff <= cnt_ff; // RULE11
      end else if (wave & wr & (adr_i == timer_channel_pkg::OFS_MATCH_B)) begin
        match_b_ff <= 16'(merge({16'h0000, match_b_ff}, dat_i, sel_i));
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_ff <= '0;
      gated_ff <= 1'b0;
      io_a_ff <= 1'b0;
      trig_pin_ff <= 1'b0;
      evt_ff <= 1'b0;
    end else begin
      presc_ff <= presc_ff + 1'b1;
      gated_ff <= gated_lvl;
      io_a_ff <= timer_io_a_i;
      trig_pin_ff <= trig_lvl;
      evt_ff <= evt_lvl;
    end
  end

  // Disable beats enable when both arrive together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_ff <= 1'b0;
      stop_ff <= 1'b0;
    end else begin
      if (dis_ev | (wr & (adr_i == timer_channel_pkg::OFS_CTRL) & sel_i[0]
                    & dat_i[timer_channel_pkg::CTRL_DISABLE])) begin
        en_ff <= 1'b0;
      end else if (wr & (adr_i == timer_channel_pkg::OFS_CTRL) & sel_i[0]
                   & dat_i[timer_channel_pkg::CTRL_ENABLE]) begin
        en_ff <= 1'b1;
      end
      if (stop_ev) begin
        stop_ff <= 1'b1;
      end else if (restart) begin
        stop_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= timer_channel_pkg::COUNT_RESET;
      cnt_chg_ff <= 1'b0;
    end else if (restart) begin
      cnt_ff <= timer_channel_pkg::COUNT_RESET;
      cnt_chg_ff <= 1'b1;
    end else begin
      cnt_chg_ff <= tick & running;
      if (tick & running) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end

  // Status bits set on events, cleared by a read; a set in the read cycle wins
  logic [7:0] ev_vec;
  always_comb begin
    ev_vec = 8'h00;
    ev_vec[timer_channel_pkg::ST_OVERFLOW] = tick & running
                                             & (cnt_ff == timer_channel_pkg::COUNT_MAX);
    ev_vec[timer_channel_pkg::ST_MATCH_A] = eq_a;
    ev_vec[timer_channel_pkg::ST_PERIOD] = eq_c;
    ev_vec[timer_channel_pkg::ST_LOAD_A] = load_a;
    ev_vec[timer_channel_pkg::ST_LOAD_B] = load_b;
    ev_vec[timer_channel_pkg::ST_TRIG] = ext_trig | ext_evt;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sticky_ff <= 8'h00;
    end else begin
      sticky_ff <= (sticky_ff & ~{8{rd_status}}) | ev_vec;
    end
  end

  // Highest-priority event with a non-null effect decides the io A level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_a_out_ff <= 1'b0;
    end else if (wave) begin
      if (sw_trig & (|mode_ff[timer_channel_pkg::F_SW_EFF_LO +: 2])) begin // RULE18
        io_a_out_ff <= apply_eff(mode_ff[timer_channel_pkg::F_SW_EFF_LO +: 2], io_a_out_ff);
      end else if (ext_evt & (|mode_ff[timer_channel_pkg::F_EVT_EFF_LO +: 2])) begin
        io_a_out_ff <= apply_eff(mode_ff[timer_channel_pkg::F_EVT_EFF_LO +: 2], io_a_out_ff);
      end else if (eq_c & (|mode_ff[timer_channel_pkg::F_PERIOD_EFF_LO +: 2])) begin
        io_a_out_ff <= apply_eff(mode_ff[timer_channel_pkg::F_PERIOD_EFF_LO +: 2], io_a_out_ff);
      end else if (eq_a) begin // RULE17
        io_a_out_ff <= apply_eff(mode_ff[timer_channel_pkg::F_MATCH_A_EFF_LO +: 2], io_a_out_ff);
      end
    end
  end

  assign timer_io_a_o.out = io_a_out_ff;
  assign timer_io_a_o.oe = wave;
  // io B waveform effects are not built; it only drives low as an output
  assign timer_io_b_o.out = 1'b0;
  assign timer_io_b_o.oe = wave & (evt_src != 2'h0); // RULE15

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A mode write inside the window would change the source under the check
  sequence s_div2_tick;
    src_sel == 3'h0 && gate_sel == 2'h0 && tick && !(wr && adr_i == timer_channel_pkg::OFS_MODE)
    ##1 !(wr && adr_i == timer_channel_pkg::OFS_MODE);
  endsequence

  AST_RESTART_ZERO: assert property (restart |=> cnt_ff == 16'h0000) // RULE8
    else $error("counter not cleared after restart");
  AST_LOADB_STOP: assert property (load_b && mode_ff[6] && !restart |=> !running) // RULE4
    else $error("clock still runs after load B with stop");
  AST_LOADB_DIS: assert property (load_b && mode_ff[7] |=> !en_ff) // RULE5
    else $error("clock still enabled after load B with disable");
  AST_PERIOD_STOP: assert property (wave && eq_c && mode_ff[6] |=> stop_ff) // RULE12
    else $error("period match did not stop clock");
  AST_PERIOD_DIS: assert property (wave && eq_c && mode_ff[7] |=> !en_ff) // RULE13
    else $error("period match did not disable clock");
  AST_IDLE_HOLD: assert property (!running && !restart |=> $stable(cnt_ff)) // RULE2
    else $error("counter moved while clock off");
  AST_LOAD_A_VALUE: assert property (load_a |=> match_a_ff == $past(cnt_ff)) // RULE10
    else $error("match A did not capture counter");
  AST_IOB_INPUT: assert property (wave && evt_src == 2'h0 |-> !timer_io_b_o.oe) // RULE15
    else $error("io B driven while used as event");
  AST_MATCH_A_SET: assert property (wave && eq_a && mode_ff[17:16] == 2'h1 && !sw_trig
                                    && !ext_evt && !eq_c |=> timer_io_a_o.out) // RULE17
    else $error("match A set did not raise io A");
  AST_DIV2: assert property (s_div2_tick |=> tick) // RULE1
    else $error("divide by two tick spacing wrong");
endmodule

// ---- tb/timer_pins_model.sv ----
// Far-side model: external clock lines and the two timer pins
`timescale 1ns/1ps
module timer_pins_model (
  input wire logic clk_i,
  output logic [2:0] ext_clock_line_o,
  output logic io_a_o,
  output logic io_b_o
);
  initial begin
    ext_clock_line_o = 3'h0;
    io_a_o = 1'b0;
    io_b_o = 1'b0;
  end
  // Burst of pulses; the line stands low between bursts
  task automatic pulse(input int idx, input int n, input int half);
    for (int k = 0; k < n; k++) begin
      repeat (half) @(posedge clk_i);
      ext_clock_line_o[idx] <= 1'b1;
      repeat (half) @(posedge clk_i);
      ext_clock_line_o[idx] <= 1'b0;
    end
  endtask
  task automatic level(input int idx, input logic v);
    @(posedge clk_i);
    ext_clock_line_o[idx] <= v;
  endtask
  task automatic set_io(input logic a, input logic b);
    @(posedge clk_i);
    io_a_o <= a;
    io_b_o <= b;
  endtask
endmodule

// ---- tb/tb_timer_channel_mode_config.sv ----
// Self-checking bench for the timer channel mode logic
`timescale 1ns/1ps
module tb_timer_channel_mode_config;
  typedef struct packed {
    logic en;
    logic [31:0] v;
  } exp_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [2:0] ext_clock_line_i;
  logic io_a_lvl;
  logic timer_io_b_i;
  timer_channel_pkg::pin_drive_s timer_io_a_o;
  timer_channel_pkg::pin_drive_s timer_io_b_o;
  // Pin level: the channel wins while it drives io A
  wire timer_io_a_i = timer_io_a_o.oe ? timer_io_a_o.out : io_a_lvl;
  exp_s rd_q[$];
  exp_s got_e;
  logic [31:0] rv;
  logic [31:0] m;
  logic [7:0] rnd;
  logic lastv;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  int i, j, tog;

  always #2.5 clk_i = ~clk_i;

  timer_channel_mode_config u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ext_clock_line_i(ext_clock_line_i), .timer_io_a_i(timer_io_a_i),
    .timer_io_a_o(timer_io_a_o), .timer_io_b_i(timer_io_b_i), .timer_io_b_o(timer_io_b_o));
  timer_pins_model u_pins (
    .clk_i(clk_i), .ext_clock_line_o(ext_clock_line_i), .io_a_o(io_a_lvl),
    .io_b_o(timer_io_b_i));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rng(input int lo, input int hi);
    check({31'h0, rv >= lo && rv <= hi}, 32'h1);
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Classic cycle; the request holds until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic en);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    if (!w) rd_q.push_back('{en, d});
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rv = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic en, input logic [31:0] e);
    wb(1'b0, a, e, en);
  endtask
  // New mode, then enable plus software trigger
  task automatic go(input logic [31:0] md);
    wr(timer_channel_pkg::OFS_MODE, md);
    wr(timer_channel_pkg::OFS_CTRL, 32'h0000_0005);
  endtask
  task automatic cnt_after(input int n);
    repeat (n) @(posedge clk_i);
    rd(timer_channel_pkg::OFS_COUNT, 1'b0, 32'h0);
  endtask
  task automatic frozen(input logic dis, input int evbit);
    logic [31:0] v;
    v = rv;
    repeat (30) @(posedge clk_i);
    rd(timer_channel_pkg::OFS_COUNT, 1'b1, v);
    rd(timer_channel_pkg::OFS_STATUS, 1'b0, 32'h0);
    check({31'h0, rv[evbit]}, 32'h1);
    if (dis) check({31'h0, rv[16]}, 32'h0);
  endtask

  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && rd_q.size() > 0) begin
      got_e = rd_q.pop_front();
      if (got_e.en) check(dat_o, got_e.v);
    end
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    rnd = 8'h4F;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(timer_channel_pkg::OFS_MODE, 1'b1, timer_channel_pkg::MODE_RESET);
    rd(8'h08, 1'b1, 32'h0);
    wr(timer_channel_pkg::OFS_MATCH_A, 32'h0000_1234);
    rd(timer_channel_pkg::OFS_MATCH_A, 1'b1, 32'h0);
    for (i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      m = {rnd, ~rnd, rnd, rnd} & 32'h00FF_DFFF;
      wr(timer_channel_pkg::OFS_MODE, m);
      rd(timer_channel_pkg::OFS_MODE, 1'b1, m);
    end
    $display("registers done");
    for (i = 0; i < 5; i++) begin
      j = (i == 4) ? 1024 : 2 << (2 * i);
      go(32'(i));
      cnt_after(64);
      rng(60 / j, 72 / j + 1);
    end
    // Ending high tells rising from falling counting
    for (i = 5; i < 8; i++) begin
      go(32'(i) | (32'(i % 2) << timer_channel_pkg::F_INVERT));
      u_pins.pulse(i - 5, 6, 3);
      u_pins.level(i - 5, 1'b1);
      repeat (8) @(posedge clk_i);
      rd(timer_channel_pkg::OFS_COUNT, 1'b1, 32'(7 - i % 2));
      u_pins.level(i - 5, 1'b0);
    end
    go(32'h0000_0020);
    cnt_after(40);
    rng(0, 0);
    u_pins.level(1, 1'b1);
    cnt_after(40);
    rng(15, 25);
    u_pins.level(1, 1'b0);
    $display("clock sources done");
    for (i = 0; i < 2; i++) begin
      go(32'h0009_0000 | (32'h40 << i));
      repeat (20) @(posedge clk_i);
      u_pins.set_io(1'b1, 1'b0);
      repeat (20) @(posedge clk_i);
      u_pins.set_io(1'b0, 1'b0);
      rd(timer_channel_pkg::OFS_MATCH_A, 1'b0, 32'h0);
      rng(8, 16);
      rd(timer_channel_pkg::OFS_MATCH_B, 1'b0, 32'h0);
      rng(18, 30);
      cnt_after(4);
      frozen(i[0], timer_channel_pkg::ST_LOAD_B);
    end
    for (i = 0; i < 4; i++) begin
      go((32'(i) << 8) | (32'(i % 2) << 10));
      repeat (60) @(posedge clk_i);
      u_pins.set_io(i % 2 == 1, i % 2 == 0);
      repeat (30) @(posedge clk_i);
      u_pins.set_io(1'b0, 1'b0);
      cnt_after(4);
      if (i == 0) rng(42, 56); else if (i == 1) rng(12, 22); else rng(0, 6);
    end
    $display("capture done");
    wr(timer_channel_pkg::OFS_MODE, 32'h0000_8000);
    wr(timer_channel_pkg::OFS_PERIOD, 32'h0000_0014);
    wr(timer_channel_pkg::OFS_MATCH_A, 32'h0000_0005);
    for (i = 0; i < 4; i++) begin
      go(32'h0000_C400 | (32'(i) << 16));
      check({31'h0, timer_io_b_o.oe}, 32'h1);
      tog = 0;
      lastv = timer_io_a_o.out;
      for (j = 0; j < 200; j++) begin
        @(posedge clk_i);
        if (timer_io_a_o.out !== lastv) tog++;
        lastv = timer_io_a_o.out;
      end
      cnt_after(1);
      rng(0, 20);
      if (i == 3) check({31'h0, tog >= 3}, 32'h1); else check({31'h0, lastv}, 32'(i == 1));
    end
    go(32'h0000_8000);
    check({31'h0, timer_io_b_o.oe}, 32'h0);
    check({31'h0, timer_io_b_o.out}, 32'h0);
    check({31'h0, timer_io_a_o.oe}, 32'h1);
    for (i = 0; i < 2; i++) begin
      go(32'h0000_8000 | (32'h40 << i));
      cnt_after(100);
      rng(20, 21);
      frozen(i[0], timer_channel_pkg::ST_PERIOD);
    end
    for (i = 0; i < 2; i++) begin
      go(32'h0000_8500 | (32'(i) << 12));
      repeat (60) @(posedge clk_i);
      u_pins.pulse(0, 1, 2);
      cnt_after(4);
      if (i == 1) rng(0, 8); else rng(30, 45);
    end
    $display("waveform done");
    complete_run();
  end
endmodule
